/* File: core/fkc_top.sv */
// Chosen here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "fkc_params.svh"
module fkc_top
  import fkc_pkg::*;
#(
  parameter int NK            = 10,
  parameter int MIN_PRESS_CYC = `FKC_MIN_PRESS_CYC
) (
  input  wire logic          hclk,             // AHB clock, 100 MHz
  input  wire logic          hresetn,          // Async reset, active low
  input  wire logic          hsel,             // Slave select
  input  wire logic [31:0]   haddr,            // Byte address
  input  wire logic [1:0]    htrans,           // Transfer type
  input  wire logic          hwrite,           // Write when high
  input  wire logic [2:0]    hsize,            // Transfer size, word only
  input  wire logic [31:0]   hwdata,           // Write data
  input  wire logic          hready,           // Bus ready
  output logic               hreadyout,        // Slave ready
  output logic               hresp,            // Always OKAY
  output logic [31:0]        hrdata,           // Read data
  input  wire logic [NK-1:0] key_pin,          // Function key pins, high when pressed
  input  wire logic          cb_hotkey_pin,    // Breaker hotkey pin
  input  wire logic          confirm_pin,      // Confirm key pin
  input  wire logic          cancel_pin,       // Cancel key pin
  input  wire logic          brk_closed_pin,   // Breaker closed indication
  input  wire logic [NK-1:0] nv_restore_data,  // Stored key states
  input  wire logic          nv_restore_valid, // Stored states available
  output logic [NK-1:0]      nv_save_data,     // Key states to store
  output logic               nv_save_we,       // Store strobe, one cycle
  output logic [NK-1:0]      scheme_logic_signal, // Key outputs to user_scheme_logic
  output logic [NK-1:0]      led_red,          // Indicator red element
  output logic [NK-1:0]      led_green,        // Indicator green element
  output logic               cb_prompt_open,   // Prompt offers opening
  output logic               cb_prompt_close,  // Prompt offers closing
  output logic               cb_pending,       // Awaiting confirm or cancel
  output logic               cb_open_cmd,      // Open command pulse
  output logic               cb_close_cmd      // Close command pulse
);
  localparam int CW = 25;
  localparam logic [CW-1:0] MIN_CYC = CW'(MIN_PRESS_CYC);

  // Bus registers
  logic              hreadyout_r;
  logic              hresp_r;
  logic [31:0]       hrdata_r;
  logic              wr_pend_r;
  logic [7:0]        wr_addr_r;
  logic              cb_en_r;
  logic [NK-1:0]     key_en_r;
  logic [NK-1:0]     key_lock_r;
  logic [NK-1:0]     key_mode_r;
  logic [2*NK-1:0]   led_cfg_r;

  // Key state
  logic [NK-1:0]     tog_r;
  logic [NK-1:0]     tog_nxt;
  logic [NK-1:0]     key_out_r;
  logic [NK-1:0]     led_red_r;
  logic [NK-1:0]     led_green_r;
  logic              restore_done_r;
  logic [NK-1:0]     nv_data_r;
  logic              nv_we_r;

  // Breaker state
  fkc_cb_st_t        cb_st_r;
  logic              hot_d_r;
  logic              conf_d_r;
  logic              canc_d_r;
  logic              prompt_open_r;
  logic              prompt_close_r;
  logic              open_cmd_r;
  logic              close_cmd_r;
  logic              pend_r;

  // Synchronised inputs
  logic [NK+3:0]     pins_s;
  logic [NK-1:0]     keys_s;
  logic              hot_s;
  logic              conf_s;
  logic              canc_s;
  logic              brk_closed_s;
  logic [NK-1:0]     held;
  logic              rec_pls;
  logic              hot_rise;
  logic              conf_rise;
  logic              canc_rise;

  function automatic logic [31:0] zext(input logic [2*NK-1:0] v);
    zext = 32'(v);
  endfunction

  fkc_sync #(
    .W (NK + 4)
  ) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       ({brk_closed_pin, cancel_pin, confirm_pin, cb_hotkey_pin, key_pin}),
    .q_r     (pins_s)
  );

  assign keys_s       = pins_s[NK-1:0];
  assign hot_s        = pins_s[NK];
  assign conf_s       = pins_s[NK+1];
  assign canc_s       = pins_s[NK+2];
  assign brk_closed_s = pins_s[NK+3];

  fkc_press_qual #(
    .NK      (NK),
    .CW      (CW),
    .MIN_CYC (MIN_CYC)
  ) u_qual (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .keys      (keys_s),
    .held_r    (held),
    .rec_pls_r (rec_pls)
  );

  // Zero-wait slave: read data is muxed at the address phase edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_r <= 1'b0;
      hresp_r     <= 1'b0;
      hrdata_r    <= 32'h0;
      wr_pend_r   <= 1'b0;
      wr_addr_r   <= 8'h00;
    end else begin
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
      wr_pend_r   <= 1'b0;
      if (hsel && htrans[1] && hready) begin
        wr_pend_r <= hwrite;
        wr_addr_r <= haddr[7:0];
        if (!hwrite) begin
          unique case (haddr[7:0])
            `FKC_OFS_CTRL:     hrdata_r <= {31'h0, cb_en_r};
            `FKC_OFS_KEY_EN:   hrdata_r <= zext({{NK{1'b0}}, key_en_r});
            `FKC_OFS_KEY_LOCK: hrdata_r <= zext({{NK{1'b0}}, key_lock_r});
            `FKC_OFS_KEY_MODE: hrdata_r <= zext({{NK{1'b0}}, key_mode_r});
            `FKC_OFS_STATE:    hrdata_r <= zext({{NK{1'b0}}, key_out_r}); // key_state_word
            `FKC_OFS_LED_CFG:  hrdata_r <= zext(led_cfg_r);
            `FKC_OFS_CB_STAT:  hrdata_r <= {26'h0, prompt_close_r, prompt_open_r, restore_done_r,
                                            cb_st_r == FKC_CB_PEND_CLS, cb_st_r == FKC_CB_PEND_OPEN,
                                            brk_closed_s};
            default:           hrdata_r <= 32'h0;
          endcase
        end
      end
    end
  end

  // Settings written in the data phase; key_enable_lock_setting and key_mode_setting
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cb_en_r    <= `FKC_CB_EN_RST;
      key_en_r   <= {NK{`FKC_KEY_EN_RST}};
      key_lock_r <= {NK{`FKC_KEY_LOCK_RST}};
      key_mode_r <= {NK{`FKC_KEY_MODE_RST}};
      led_cfg_r  <= {NK{`FKC_LED_CFG_RST}};
    end else if (wr_pend_r) begin
      unique case (wr_addr_r)
        `FKC_OFS_CTRL:     cb_en_r    <= hwdata[`FKC_CTRL_CB_EN];
        `FKC_OFS_KEY_EN:   key_en_r   <= hwdata[NK-1:0];
        `FKC_OFS_KEY_LOCK: key_lock_r <= hwdata[NK-1:0];
        `FKC_OFS_KEY_MODE: key_mode_r <= hwdata[NK-1:0];
        `FKC_OFS_LED_CFG:  led_cfg_r  <= hwdata[2*NK-1:0];
        default: ;
      endcase
    end
  end

  // Toggle state: once restored, a recognised press of a toggle-mode key flips it unless locked or disabled
  always_comb begin
    tog_nxt = tog_r;
    if (!restore_done_r) begin
      if (nv_restore_valid) begin
        tog_nxt = nv_restore_data;
      end
    end else if (rec_pls) begin
      tog_nxt = tog_r ^ (held & key_mode_r & key_en_r & ~key_lock_r);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tog_r          <= '0;
      restore_done_r <= 1'b0;
    end else begin
      tog_r <= tog_nxt;
      if (nv_restore_valid) begin
        restore_done_r <= 1'b1;
      end
    end
  end

  // Save every change after restore so a supply loss keeps the states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nv_data_r <= '0;
      nv_we_r   <= 1'b0;
    end else begin
      nv_data_r <= tog_nxt;
      nv_we_r   <= restore_done_r && (tog_nxt != tog_r);
    end
  end

  // Key outputs; a minimum pulse in normal mode is left to the scheme logic
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      key_out_r <= '0;
    end else begin
      key_out_r <= key_en_r & ((key_mode_r & tog_r) | (~key_mode_r & ~key_lock_r & held));
    end
  end

  // Indicator follows the key output in its programmed colour
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      led_red_r   <= '0;
      led_green_r <= '0;
    end else begin
      for (int i = 0; i < NK; i++) begin
        led_red_r[i]   <= key_out_r[i] & led_cfg_r[2*i];
        led_green_r[i] <= key_out_r[i] & led_cfg_r[2*i+1];
      end
    end
  end

  // Edge detect of the already filtered control keys
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hot_d_r  <= 1'b0;
      conf_d_r <= 1'b0;
      canc_d_r <= 1'b0;
    end else begin
      hot_d_r  <= hot_s;
      conf_d_r <= conf_s;
      canc_d_r <= canc_s;
    end
  end
  assign hot_rise  = hot_s & ~hot_d_r;
  assign conf_rise = conf_s & ~conf_d_r;
  assign canc_rise = canc_s & ~canc_d_r;

  // Breaker hotkey: press only arms; confirm fires, cancel drops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cb_st_r     <= FKC_CB_IDLE;
      open_cmd_r  <= 1'b0;
      close_cmd_r <= 1'b0;
    end else begin
      open_cmd_r  <= 1'b0;
      close_cmd_r <= 1'b0;
      unique case (cb_st_r)
        FKC_CB_IDLE: begin
          if (cb_en_r && hot_rise) begin
            cb_st_r <= brk_closed_s ? FKC_CB_PEND_OPEN : FKC_CB_PEND_CLS;
          end
        end
        FKC_CB_PEND_OPEN, FKC_CB_PEND_CLS: begin
          if (!cb_en_r || canc_rise) begin
            cb_st_r <= FKC_CB_IDLE;
          end else if (conf_rise) begin
            cb_st_r     <= FKC_CB_IDLE;
            open_cmd_r  <= (cb_st_r == FKC_CB_PEND_OPEN);
            close_cmd_r <= (cb_st_r == FKC_CB_PEND_CLS);
          end
        end
        default: cb_st_r <= FKC_CB_IDLE;
      endcase
    end
  end

  // Prompt shows the opposite of the breaker position
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prompt_open_r  <= 1'b0;
      prompt_close_r <= 1'b0;
      pend_r         <= 1'b0;
    end else begin
      prompt_open_r  <= cb_en_r & brk_closed_s;
      prompt_close_r <= cb_en_r & ~brk_closed_s;
      pend_r         <= (cb_st_r != FKC_CB_IDLE); // Registered so the pin comes from a flip-flop
    end
  end

  assign hreadyout           = hreadyout_r;
  assign hresp               = hresp_r;
  assign hrdata              = hrdata_r;
  assign nv_save_data        = nv_data_r;
  assign nv_save_we          = nv_we_r;
  assign scheme_logic_signal = key_out_r;
  assign led_red             = led_red_r;
  assign led_green           = led_green_r;
  assign cb_prompt_open      = prompt_open_r;
  assign cb_prompt_close     = prompt_close_r;
  assign cb_pending          = pend_r;
  assign cb_open_cmd         = open_cmd_r;
  assign cb_close_cmd        = close_cmd_r;

  a_cb_disabled:
  assert property (@(posedge hclk) disable iff (!hresetn)
    !cb_en_r |=> !open_cmd_r && !close_cmd_r && !prompt_open_r && !prompt_close_r)
    else $error("Breaker control active while disabled");

  a_cb_prompt:
  assert property (@(posedge hclk) disable iff (!hresetn)
    cb_en_r |=> prompt_open_r == $past(brk_closed_s) && prompt_close_r == !$past(brk_closed_s))
    else $error("Prompt does not oppose breaker state");

  a_cb_confirm:
  assert property (@(posedge hclk) disable iff (!hresetn)
    (open_cmd_r || close_cmd_r) |-> $past(conf_rise) && !$past(canc_rise) && $past(cb_st_r) != FKC_CB_IDLE)
    else $error("Breaker command without confirm");

  a_state_word:
  assert property (@(posedge hclk) disable iff (!hresetn)
    hsel && htrans[1] && hready && !hwrite && haddr[7:0] == `FKC_OFS_STATE
    |=> hrdata_r[NK-1:0] == $past(key_out_r))
    else $error("State word read mismatch");

  a_key_disabled:
  assert property (@(posedge hclk) disable iff (!hresetn)
    (key_out_r & ~$past(key_en_r)) == '0)
    else $error("Disabled key drives output");

  a_toggle_lock:
  assert property (@(posedge hclk) disable iff (!hresetn)
    $past(restore_done_r) |-> ((tog_r ^ $past(tog_r)) & $past(key_lock_r)) == '0)
    else $error("Locked toggled key changed");

  a_normal_lock:
  assert property (@(posedge hclk) disable iff (!hresetn)
    (key_out_r & ~$past(key_mode_r) & $past(key_lock_r)) == '0)
    else $error("Locked normal key active");

  a_toggle_flip:
  assert property (@(posedge hclk) disable iff (!hresetn)
    restore_done_r && rec_pls |=> tog_r == ($past(tog_r) ^ ($past(held) & $past(key_mode_r) & $past(key_en_r) & ~$past(key_lock_r))))
    else $error("Toggle state did not follow press");

  a_normal_follow:
  assert property (@(posedge hclk) disable iff (!hresetn)
    ((key_out_r ^ ($past(held) & $past(key_en_r) & ~$past(key_lock_r))) & ~$past(key_mode_r)) == '0)
    else $error("Normal key output does not follow press");

  a_nv_save:
  assert property (@(posedge hclk) disable iff (!hresetn)
    $past(restore_done_r) && tog_r != $past(tog_r) |-> nv_we_r && nv_data_r == tog_r)
    else $error("Key state change not saved");
endmodule
`default_nettype wire

/* File: core/fkc_params.svh */
`ifndef FKC_PARAMS_SVH
`define FKC_PARAMS_SVH

// Register byte offsets on the AHB-Lite slave
`define FKC_OFS_CTRL      8'h00
`define FKC_OFS_KEY_EN    8'h04
`define FKC_OFS_KEY_LOCK  8'h08
`define FKC_OFS_KEY_MODE  8'h0C
`define FKC_OFS_STATE     8'h10
`define FKC_OFS_LED_CFG   8'h14
`define FKC_OFS_CB_STAT   8'h18

// Field positions
`define FKC_CTRL_CB_EN    0
`define FKC_CBS_CLOSED    0
`define FKC_CBS_PEND_OPN  1
`define FKC_CBS_PEND_CLS  2
`define FKC_CBS_RESTORED  3
`define FKC_CBS_PROMPT_OP 4
`define FKC_CBS_PROMPT_CL 5

// Reset values (enable, lock and mode are replicated per key)
`define FKC_CB_EN_RST     1'b0
`define FKC_KEY_EN_RST    1'b1
`define FKC_KEY_LOCK_RST  1'b0
`define FKC_KEY_MODE_RST  1'b0
`define FKC_LED_CFG_RST   2'h1

// Timing
`define FKC_CLK_MHZ       100
`define FKC_MIN_PRESS_MS  200
`define FKC_MIN_PRESS_CYC (`FKC_MIN_PRESS_MS * `FKC_CLK_MHZ * 1000)

`endif

/* File: core/fkc_pkg.sv */
package fkc_pkg;

  // Breaker hotkey sequence
  typedef enum logic [1:0] {
    FKC_CB_IDLE      = 2'b00,
    FKC_CB_PEND_OPEN = 2'b01,
    FKC_CB_PEND_CLS  = 2'b10
  } fkc_cb_st_t;

  // Press qualification
  typedef enum logic [1:0] {
    FKC_Q_IDLE  = 2'b00,
    FKC_Q_COUNT = 2'b01,
    FKC_Q_HELD  = 2'b10,
    FKC_Q_WAIT  = 2'b11
  } fkc_q_st_t;

endpackage

/* File: core/fkc_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module fkc_sync #(
  parameter int W = 1
) (
  input  wire logic         hclk,    // System clock
  input  wire logic         hresetn, // Async reset, active low
  input  wire logic [W-1:0] d,       // Raw pin levels
  output logic      [W-1:0] q_r      // Filtered level
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // Three stages; a change is taken only once stages two and three agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_r  <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r  <= (s2_r & s3_r) | (q_r & (s2_r | s3_r)); // Hold on disagreement
    end
  end
endmodule
`default_nettype wire

/* File: core/fkc_press_qual.sv */
`timescale 1ns/100ps
`default_nettype none
module fkc_press_qual
  import fkc_pkg::*;
#(
  parameter int               NK      = 10,
  parameter int               CW      = 25,
  parameter logic [CW-1:0]    MIN_CYC = 25'd20000000
) (
  input  wire logic          hclk,      // System clock
  input  wire logic          hresetn,   // Async reset, active low
  input  wire logic [NK-1:0] keys,      // Synchronised key levels
  output logic      [NK-1:0] held_r,    // One-hot recognised key, level
  output logic               rec_pls_r  // Pulse at recognition
);
  fkc_q_st_t      st_r;
  logic [NK-1:0]  cand_r;
  logic [CW-1:0]  cnt_r;

  function automatic logic is_onehot(input logic [NK-1:0] k);
    is_onehot = (k != '0) && ((k & (k - 1'b1)) == '0);
  endfunction

  // One key at a time; any overlap waits for full release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r      <= FKC_Q_IDLE;
      cand_r    <= '0;
      cnt_r     <= '0;
      held_r    <= '0;
      rec_pls_r <= 1'b0;
    end else begin
      rec_pls_r <= 1'b0;
      unique case (st_r)
        FKC_Q_IDLE: begin
          if (keys != '0) begin
            if (is_onehot(keys)) begin
              st_r   <= FKC_Q_COUNT;
              cand_r <= keys;
              cnt_r  <= '0;
            end else begin
              st_r <= FKC_Q_WAIT;
            end
          end
        end
        FKC_Q_COUNT: begin
          if (keys == '0) begin
            st_r <= FKC_Q_IDLE; // Short press discarded
          end else if (keys != cand_r) begin
            st_r <= FKC_Q_WAIT;
          end else if (cnt_r == MIN_CYC - 1'b1) begin
            st_r      <= FKC_Q_HELD;
            held_r    <= cand_r;
            rec_pls_r <= 1'b1;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        FKC_Q_HELD: begin
          if (keys != cand_r) begin
            held_r <= '0;
            st_r   <= (keys == '0) ? FKC_Q_IDLE : FKC_Q_WAIT;
          end
        end
        FKC_Q_WAIT: begin
          if (keys == '0) begin
            st_r <= FKC_Q_IDLE;
          end
        end
      endcase
    end
  end

  a_single_held:
  assert property (@(posedge hclk) disable iff (!hresetn) $onehot0(held_r))
    else $error("More than one key recognised");

  a_press_duration:
  assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(rec_pls_r) |-> $past(cnt_r) == MIN_CYC - 1'b1 && $past(st_r) == FKC_Q_COUNT)
    else $error("Press recognised before minimum duration");

  a_wait_release:
  assert property (@(posedge hclk) disable iff (!hresetn)
    st_r == FKC_Q_WAIT && keys != '0 |=> st_r == FKC_Q_WAIT && held_r == '0)
    else $error("Left wait state while keys still pressed");
endmodule
`default_nettype wire

/* File: tb/fkc_pad.sv */
`timescale 1ns/100ps
`default_nettype none
// Keypad, storage and scheme logic side of the key block
module fkc_pad #(
  parameter int NK = 10
) (
  input  wire logic          hclk,             // System clock
  input  wire logic [NK+2:0] req,              // Bench request: cancel, confirm, hotkey, keys
  input  wire logic [NK-1:0] nv_save_data,     // States to keep
  input  wire logic          nv_save_we,       // Store strobe
  input  wire logic [NK-1:0] scheme_logic_signal, // Key outputs
  output logic      [NK-1:0] key_pin,          // Key contacts
  output logic               cb_hotkey_pin,    // Hotkey contact
  output logic               confirm_pin,      // Confirm contact
  output logic               cancel_pin,       // Cancel contact
  output logic      [NK-1:0] nv_restore_data,  // Stored states
  output logic               nv_restore_valid, // Storage ready
  output logic      [NK-1:0] min_pulse         // Stretched key outputs
);
  logic [NK-1:0] store_r;
  logic [3:0]    pulse_cnt_r;
  logic [NK-1:0] last_r;
  // Contacts change just after the edge, as a person's finger would
  always_ff @(posedge hclk) begin
    {cancel_pin, confirm_pin, cb_hotkey_pin, key_pin} <= req;
  end
  // Storage has no reset: it must outlive a supply loss
  initial store_r = '0;
  always @(posedge hclk) begin
    if (nv_save_we) begin
      store_r <= nv_save_data;
    end
  end
  assign nv_restore_data  = store_r;
  assign nv_restore_valid = 1'b1;
  // Scheme logic stretches a normal key pulse to a minimum width
  initial pulse_cnt_r = '0;
  always @(posedge hclk) begin
    if (|scheme_logic_signal) begin
      pulse_cnt_r <= 4'hF;
      last_r      <= scheme_logic_signal;
    end else if (pulse_cnt_r != 4'h0) begin
      pulse_cnt_r <= pulse_cnt_r - 4'h1;
    end
  end
  // Last active outputs are held on until the stretch runs out
  assign min_pulse = scheme_logic_signal | ((pulse_cnt_r != 4'h0) ? last_r : '0);
endmodule
`default_nettype wire

/* File: tb/fkc_top_test.sv */
`timescale 1ns/100ps
`default_nettype none
`include "fkc_params.svh"
`define CHK(o, e) begin n_compared++; if ((o) !== (e)) begin err_count++; \
  $display("Error at %0t: got %h expected %h", $time, o, e); end end
module fkc_top_test;
  import fkc_pkg::*;
  localparam int NK = 10;
  logic hclk, hresetn, hwrite, hreadyout, hresp, brk, nv_we, valid;
  logic [31:0] haddr, hwdata, hrdata, r, got_v, exp_v;
  logic [1:0] htrans;
  logic [NK+2:0] req;
  logic [NK-1:0] keys, nv_d, nv_q, sls, red, green, stretched;
  logic hot, conf, canc, p_op, p_cl, pend, op_cmd, cl_cmd;
  logic [31:0] exp_q[$], obs_q[$];
  int err_count, n_compared, n_open, n_close, k;
  fkc_top #(.NK(NK), .MIN_PRESS_CYC(20)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .key_pin(keys), .cb_hotkey_pin(hot),
    .confirm_pin(conf), .cancel_pin(canc), .brk_closed_pin(brk), .nv_restore_data(nv_q),
    .nv_restore_valid(valid), .nv_save_data(nv_d), .nv_save_we(nv_we), .scheme_logic_signal(sls),
    .led_red(red), .led_green(green), .cb_prompt_open(p_op), .cb_prompt_close(p_cl),
    .cb_pending(pend), .cb_open_cmd(op_cmd), .cb_close_cmd(cl_cmd));
  fkc_pad #(.NK(NK)) pad (.hclk(hclk), .req(req), .nv_save_data(nv_d), .nv_save_we(nv_we),
    .scheme_logic_signal(sls), .key_pin(keys), .cb_hotkey_pin(hot), .confirm_pin(conf),
    .cancel_pin(canc), .nv_restore_data(nv_q), .nv_restore_valid(valid), .min_pulse(stretched));
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // Results are noted in order, the checker matches them oldest first
  task automatic chk(input logic [31:0] o, input logic [31:0] e);
    exp_q.push_back(e);
    obs_q.push_back(o);
  endtask
  initial forever begin
    wait (obs_q.size() > 0);
    got_v = obs_q.pop_front();
    exp_v = exp_q.pop_front();
    `CHK(got_v, exp_v)
  end
  // One AHB-Lite single word transfer, no wait state count assumed
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(r, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // Press for len cycles, look while held and after release
  task automatic key(input logic [NK+2:0] m, input int len, input logic [31:0] eh, input logic [31:0] ea);
    req <= m;
    cyc(len);
    rd(`FKC_OFS_STATE, eh);
    req <= '0;
    cyc(15);
    rd(`FKC_OFS_STATE, ea);
  endtask
  task automatic stop_test();
    $display("Compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge hclk) begin
    n_open  += (op_cmd === 1'b1);
    n_close += (cl_cmd === 1'b1);
  end
  initial begin
    #200000;
    err_count++;
    stop_test();
  end
  initial begin
    {hresetn, hwrite, htrans, haddr, hwdata, req} = '0;
    brk = 1'b1;
    void'($urandom(47730));
    cyc(12);
    hresetn <= 1'b1;
    cyc(1);
    rd(`FKC_OFS_CTRL, 32'h0);
    rd(`FKC_OFS_KEY_EN, 32'h3FF);
    rd(`FKC_OFS_KEY_MODE, 32'h0);
    rd(`FKC_OFS_LED_CFG, 32'h55555);
    rd(`FKC_OFS_CB_STAT, 32'h9);
    bus(8'h1C, 1'b1, $urandom);
    rd(8'h1C, 32'h0);
    key(13'h400, 12, 32'h0, 32'h0);
    chk(pend, 1'b0);
    k = $urandom % NK;
    key(13'h1 << k, 40, 32'h1 << k, 32'h0);
    chk(stretched, 32'h1 << k);
    key(13'h1 << k, 10, 32'h0, 32'h0);
    key(13'h3, 40, 32'h0, 32'h0);
    // Second key during a hold is never taken on its own
    req <= 13'h2;
    cyc(35);
    req <= 13'h12;
    cyc(5);
    req <= 13'h10;
    cyc(40);
    rd(`FKC_OFS_STATE, 32'h0);
    req <= '0;
    cyc(15);
    bus(`FKC_OFS_KEY_MODE, 1'b1, 32'h1);
    key(13'h1, 40, 32'h1, 32'h1);
    key(13'h1, 40, 32'h0, 32'h0);
    key(13'h1, 40, 32'h1, 32'h1);
    chk({green[0], red[0]}, 2'h1);
    bus(`FKC_OFS_LED_CFG, 1'b1, 32'h55557);
    cyc(3);
    chk({green[0], red[0]}, 2'h3);
    bus(`FKC_OFS_KEY_LOCK, 1'b1, 32'h5);
    key(13'h1, 40, 32'h1, 32'h1);
    key(13'h4, 40, 32'h1, 32'h1);
    bus(`FKC_OFS_KEY_EN, 1'b1, 32'h3F7);
    key(13'h8, 40, 32'h1, 32'h1);
    // Supply loss: toggle state must come back from storage
    hresetn <= 1'b0;
    cyc(3);
    hresetn <= 1'b1;
    cyc(2);
    bus(`FKC_OFS_KEY_MODE, 1'b1, 32'h1);
    cyc(3);
    rd(`FKC_OFS_STATE, 32'h1);
    bus(`FKC_OFS_CTRL, 1'b1, 32'h1);
    cyc(3);
    rd(`FKC_OFS_CB_STAT, 32'h19);
    key(13'h400, 8, 32'h1, 32'h1);
    chk(pend, 1'b1);
    key(13'h1000, 8, 32'h1, 32'h1);
    chk({pend, n_open[0]}, 2'h0);
    key(13'h400, 8, 32'h1, 32'h1);
    key(13'h800, 8, 32'h1, 32'h1);
    chk(n_open, 1);
    brk <= 1'b0;
    cyc(6);
    rd(`FKC_OFS_CB_STAT, 32'h28);
    key(13'h400, 8, 32'h1, 32'h1);
    key(13'h800, 8, 32'h1, 32'h1);
    chk({n_close[1:0], n_open[1:0]}, 4'h5);
    cyc(5);
    stop_test();
  end
endmodule
`default_nettype wire
